// ---- bench/pfc_cpu.sv ----
/* cpu side of the flag block's register port: single word writes and reads.
   assumes the bench calls wr and rd one at a time, never overlapping. */
`timescale 1ns/1ns
module pfc_cpu (
  // clock
  input wire clk_sys,
  // register port
  output logic [15:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire [15:0] reg_rdata_q,
  input wire reg_rvalid_q
);
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = 34'h0;
  end
  // released lines show the inverse so a stale value never looks live
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [16:0] q);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    q = {reg_rvalid_q, reg_rdata_q};
  endtask
endmodule // pfc_cpu

// ---- bench/pfc_flag_ctrl_properties.sv ----
/* concurrent checks on the flag set / clear / enable block.
   assumes it is bound onto pfc_flag_ctrl, one clock domain. */
`timescale 1ns/1ns
module pfc_flag_ctrl_properties (
  // clock and control
  input wire clk_sys,
  input wire srst,
  input wire ce,
  // register port
  input wire [15:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata_q,
  input wire reg_rvalid_q,
  // events and state
  input wire [15:0] hw_event_set,
  input wire [15:0] event_status_flags,
  input wire [13:0] irq_request_q,
  input wire auto_idle_enable_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  wire wr_set = ce && reg_wr && reg_addr == 16'he8d2;
  wire wr_clr = ce && reg_wr && reg_addr == 16'he8d4;
  a_set_sets: assert property (wr_set |=>
    (event_status_flags & $past(reg_wdata) & 16'h77ff) == ($past(reg_wdata) & 16'h77ff))
    else $error("set strobe missed a flag");
  a_clr_clears: assert property (wr_clr && hw_event_set == 0 |=>
    (event_status_flags & $past(reg_wdata) & 16'h77ff) == 0) else $error("clear missed");
  a_strobe_zero: assert property (ce && reg_rd && reg_addr[15:3] == 13'h1d1a |=>
    reg_rvalid_q && reg_rdata_q == 0) else $error("strobe read not zero");
  a_irq_gated: assert property (
    (irq_request_q & ~$past(event_status_flags[13:0])) == 0) else $error("request without flag");
  a_holes_zero: assert property (
    !event_status_flags[15] && !event_status_flags[11] && !irq_request_q[11]) else $error("hole set");
  a_idle_sticky: assert property (event_status_flags[14] && !(wr_clr && reg_wdata[14])
    |=> event_status_flags[14]) else $error("idle flag dropped");
  a_hw_set_wins: assert property (ce && hw_event_set != 0 |=>
    (event_status_flags & $past(hw_event_set) & 16'h77ff) == ($past(hw_event_set) & 16'h77ff))
    else $error("event lost");
  a_idle_follow: assert property (ce && auto_idle_enable_q && hw_event_set[13]
    |=> event_status_flags[14]) else $error("idle not entered");
endmodule // pfc_flag_ctrl_properties
bind pfc_flag_ctrl pfc_flag_ctrl_properties i_pfc_flag_ctrl_properties (
  .clk_sys(clk_sys), .srst(srst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
  .hw_event_set(hw_event_set), .event_status_flags(event_status_flags),
  .irq_request_q(irq_request_q), .auto_idle_enable_q(auto_idle_enable_q)
);

// ---- bench/tb.sv ----
/* self-checking bench for the flag set / clear / enable block.
   assumes the cpu model and the bound checker are compiled first. */
`timescale 1ns/1ns
module tb;
  logic clk_sys, srst, ce;
  logic [15:0] hw_event_set, hw_event_clear;
  wire [15:0] reg_addr, reg_wdata, reg_rdata_q, event_status_flags;
  wire reg_wr, reg_rd, reg_rvalid_q, auto_idle_enable_q, idle_entry_q;
  wire [13:0] irq_request_q;
  logic [16:0] q;
  int n_mismatch = 0;
  int tests_run = 0;
  pfc_flag_ctrl i_pfc_flag_ctrl (
    .clk_sys(clk_sys), .srst(srst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
    .hw_event_set(hw_event_set), .hw_event_clear(hw_event_clear),
    .event_status_flags(event_status_flags), .irq_request_q(irq_request_q),
    .auto_idle_enable_q(auto_idle_enable_q), .idle_entry_q(idle_entry_q)
  );
  pfc_cpu i_cpu (
    .clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q)
  );
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic t_bits;
    i_cpu.rd(16'he8d8, q);
    chk(q, 17'h10000);
    for (int i = 0; i < 16; i++) begin
      i_cpu.wr(16'he8d2, 16'h0001 << i);
      chk(event_status_flags, (16'h0001 << i) & 16'h77ff);
      i_cpu.wr(16'he8d4, 16'h0001 << i);
      chk(event_status_flags, 16'h0000);
    end
    i_cpu.wr(16'he8d2, 16'hffff);
    i_cpu.wr(16'he8d2, 16'h0000);
    chk(event_status_flags, 16'h77ff);
    i_cpu.wr(16'he8d4, 16'h0000);
    chk(event_status_flags, 16'h77ff);
    // unmapped word first, then both strobes, all with flags up
    for (int a = 0; a < 3; a++) begin
      i_cpu.rd(16'he8d0 + 16'h0002 * a, q);
      chk(q, 17'h10000);
    end
  endtask
  task automatic t_enable;
    i_cpu.wr(16'he8d8, 16'hffff);
    tick;
    chk(irq_request_q, 14'h37ff);
    i_cpu.rd(16'he8d8, q);
    chk(q, 17'h177ff);
    i_cpu.wr(16'he8d4, 16'hffff);
    i_cpu.wr(16'he8d8, 16'h0001);
    i_cpu.rd(16'he8d2, q);
    i_cpu.wr(16'he8d2, q[15:0] | 16'h0003);
    chk(event_status_flags, 16'h0003);
    tick;
    chk(irq_request_q, 14'h0001);
    i_cpu.wr(16'he8d8, 16'h0000);
    tick;
    chk(irq_request_q, 14'h0000);
  endtask
  task automatic t_idle;
    i_cpu.wr(16'he8d4, 16'hffff);
    i_cpu.wr(16'he8d8, 16'h4000);
    chk(auto_idle_enable_q, 1'b1);
    hw_event_set = 16'h2000;
    tick;
    hw_event_set = 16'h0000;
    chk(event_status_flags, 16'h6000);
    chk(idle_entry_q, 1'b0);
    hw_event_clear = 16'h6000;
    tick;
    hw_event_clear = 16'h0000;
    chk(event_status_flags, 16'h4000);
    chk(idle_entry_q, 1'b1);
    fork
      i_cpu.wr(16'he8d4, 16'h4001);
      begin
        tick;
        hw_event_set = 16'h0001;
        tick;
        hw_event_set = 16'h0000;
      end
    join
    chk(event_status_flags, 16'h0001);
  endtask
  // ce low must hold flags and outputs; then a reset in mid-run
  task automatic t_freeze;
    ce = 1'b0;
    hw_event_set = 16'h0004;
    i_cpu.wr(16'he8d2, 16'h0002);
    hw_event_set = 16'h0000;
    chk(event_status_flags, 16'h0001);
    chk(idle_entry_q, 1'b1);
    ce = 1'b1;
    i_cpu.wr(16'he8d2, 16'h0002);
    chk(event_status_flags, 16'h0003);
    srst = 1'b1;
    tick;
    srst = 1'b0;
    chk(event_status_flags, 16'h0000);
    chk({auto_idle_enable_q, idle_entry_q, irq_request_q}, 16'h0000);
    i_cpu.rd(16'he8d8, q);
    chk(q, 17'h10000);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    srst = 1'b1;
    ce = 1'b1;
    hw_event_set = 16'h0000;
    hw_event_clear = 16'h0000;
    repeat (12) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    t_bits;
    t_enable;
    t_idle;
    t_freeze;
    end_sim;
  end
  // whole run is about 125 cycles; this leaves wide margin
  initial begin
    #20000;
    n_mismatch++;
    end_sim;
  end
endmodule // tb

// ---- hdl/pfc_defines.vh ----
/*
 * constants for the flag set / clear / enable block: register offsets,
 * field positions, masks and reset values.
 * assumes inclusion by bare name from every design file that needs them.
 */
`ifndef PFC_DEFINES_VH
`define PFC_DEFINES_VH

// ****************************************************
// widths
// ****************************************************
`define PFC_DATA_W 16
`define PFC_ADDR_W 16
`define PFC_IRQ_W 14

// ****************************************************
// register offsets, as printed on the peripheral bus
// ****************************************************
`define PFC_OFS_FLAG_SET 16'he8d2
`define PFC_OFS_FLAG_CLR 16'he8d4
`define PFC_OFS_IRQ_EN 16'he8d8

// ****************************************************
// decoder selects
// ****************************************************
`define PFC_SEL_NONE 2'h0
`define PFC_SEL_SET 2'h1
`define PFC_SEL_CLR 2'h2
`define PFC_SEL_EN 2'h3

// ****************************************************
// field positions
// ****************************************************
`define PFC_BIT_IDLE 14
`define PFC_BIT_WRONG_HALL 13
`define PFC_BIT_CORRECT_HALL 12
`define PFC_BIT_TRAP_STATE 11
`define PFC_BIT_TRAP 10
`define PFC_BIT_TB_PERIOD 9
`define PFC_BIT_TB_COMPARE 8
`define PFC_BIT_TA_PERIOD 7
`define PFC_BIT_TA_ONE 6
`define PFC_BIT_CH2_FALL 5
`define PFC_BIT_CH2_RISE 4
`define PFC_BIT_CH1_FALL 3
`define PFC_BIT_CH1_RISE 2
`define PFC_BIT_CH0_FALL 1
`define PFC_BIT_CH0_RISE 0

// ****************************************************
// masks and reset values
// ****************************************************
// bits 15 and 11 are not backed by any flag or enable
`define PFC_IMPL_MASK 16'h77ff
// flags that may raise a request: 13 down to 0, less bit 11
`define PFC_IRQ_MASK 16'h37ff
// the idle flag is cleared by software only
`define PFC_HW_CLR_MASK 16'h37ff
`define PFC_RST_FLAGS 16'h0000
`define PFC_RST_EN 16'h0000
`define PFC_RST_RDATA 16'h0000
`define PFC_RST_IRQ 14'h0000
`define PFC_ZERO 16'h0000

`endif

// ---- hdl/pfc_flag_cell.v ----
/*
 * one sticky status flag with hardware and software set and clear.
 * assumes all inputs are synchronous to clk_sys and single-cycle pulses.
 */
`timescale 1ns/1ns

module pfc_flag_cell (
  // clock and control
  input wire clk_sys,
  input wire srst,
  input wire ce,
  // set and clear sources
  input wire set_hw,
  input wire set_sw,
  input wire clr_hw,
  input wire clr_sw,
  // state
  output reg flag_q
);

  wire set_any;
  wire clr_any;

  assign set_any = set_hw | set_sw;
  assign clr_any = clr_hw | clr_sw;

  always @(posedge clk_sys) begin
    if (srst) begin
      flag_q <= 1'b0;
    end else if (ce) begin
      // set is tested first so an event meeting a clear is never lost
      if (set_any) begin
        flag_q <= 1'b1;
      end else if (clr_any) begin
        flag_q <= 1'b0;
      end
    end
  end

endmodule // pfc_flag_cell

// ---- hdl/pfc_flag_ctrl.v ----
/*
 * flag set / clear strobes, interrupt enable register and the sticky
 * event flags they act on, with per-source request outputs.
 * assumes a simple synchronous peripheral port: one write or read strobe
 * per cycle, word-wide data, and event inputs that are one-cycle pulses
 * synchronous to clk_sys.
 */
`timescale 1ns/1ns
`include "pfc_defines.vh"

module pfc_flag_ctrl (
  // clock, reset, enable
  input wire clk_sys,
  input wire srst,
  input wire ce,
  // peripheral register port
  input wire [`PFC_ADDR_W-1:0] reg_addr,
  input wire [`PFC_DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`PFC_DATA_W-1:0] reg_rdata_q,
  output reg reg_rvalid_q,
  // hardware event sources, one bit per flag position
  input wire [`PFC_DATA_W-1:0] hw_event_set,
  input wire [`PFC_DATA_W-1:0] hw_event_clear,
  // flag state and requests
  output wire [`PFC_DATA_W-1:0] event_status_flags,
  output reg [`PFC_IRQ_W-1:0] irq_request_q,
  output reg auto_idle_enable_q,
  output reg idle_entry_q
);

  // ****************************************************
  // address decoding
  // ****************************************************
  function [1:0] pfc_decode;
    input [`PFC_ADDR_W-1:0] addr;
    begin
      case (addr)
        `PFC_OFS_FLAG_SET: pfc_decode = `PFC_SEL_SET;
        `PFC_OFS_FLAG_CLR: pfc_decode = `PFC_SEL_CLR;
        `PFC_OFS_IRQ_EN: pfc_decode = `PFC_SEL_EN;
        default: pfc_decode = `PFC_SEL_NONE;
      endcase
    end
  endfunction

  localparam [`PFC_DATA_W-1:0] IMPL_MASK = `PFC_IMPL_MASK;
  localparam [`PFC_DATA_W-1:0] IRQ_MASK = `PFC_IRQ_MASK;
  localparam [`PFC_DATA_W-1:0] HW_CLR_MASK = `PFC_HW_CLR_MASK;

  wire [1:0] wr_sel;
  wire [1:0] rd_sel;
  wire wr_set;
  wire wr_clr;
  wire wr_en;

  // reads and writes share one map; a write to an unmapped word is
  // dropped and a read of one answers zero
  assign wr_sel = pfc_decode(reg_addr);
  assign rd_sel = pfc_decode(reg_addr);
  // a plain move, a read-modify-write OR and a single-bit set all end
  // in one write here; since strobes read as zero, the merged value
  // carries only the bits software meant to touch
  assign wr_set = reg_wr & (wr_sel == `PFC_SEL_SET);
  assign wr_clr = reg_wr & (wr_sel == `PFC_SEL_CLR);
  assign wr_en = reg_wr & (wr_sel == `PFC_SEL_EN);

  // ****************************************************
  // enable register
  // ****************************************************
  reg [`PFC_DATA_W-1:0] irq_en_q;
  reg [`PFC_DATA_W-1:0] irq_en_d;

  always @* begin
    irq_en_d = irq_en_q;
    if (wr_en) begin
      irq_en_d = reg_wdata & IMPL_MASK;
    end
  end

  // ce low holds every register; strobes and events seen meanwhile are
  // not taken, so a source must hold them until ce returns
  always @(posedge clk_sys) begin
    if (srst) begin
      irq_en_q <= `PFC_RST_EN;
    end else if (ce) begin
      irq_en_q <= irq_en_d;
    end
  end

  // ****************************************************
  // set and clear vectors
  // ****************************************************
  wire [`PFC_DATA_W-1:0] sw_set;
  wire [`PFC_DATA_W-1:0] sw_clr;
  wire [`PFC_DATA_W-1:0] hw_set;
  wire [`PFC_DATA_W-1:0] hw_clr;
  wire wrong_hall_set;
  wire idle_follow;

  // same positions in both strobes; unbacked bits are dropped
  assign sw_set = wr_set ? (reg_wdata & IMPL_MASK) : `PFC_ZERO;
  assign sw_clr = wr_clr ? (reg_wdata & IMPL_MASK) : `PFC_ZERO;

  // a wrong hall flag, however it is set, drags the idle flag along
  // when the automatic idle reaction is armed
  assign wrong_hall_set = hw_event_set[`PFC_BIT_WRONG_HALL] | sw_set[`PFC_BIT_WRONG_HALL];
  assign idle_follow = irq_en_q[`PFC_BIT_IDLE] & wrong_hall_set;

  generate
    genvar b;
    for (b = 0; b < `PFC_DATA_W; b = b + 1) begin : g_hw
      if (b == `PFC_BIT_IDLE) begin : g_idle
        assign hw_set[b] = hw_event_set[b] | idle_follow;
      end else begin : g_plain
        assign hw_set[b] = hw_event_set[b] & IMPL_MASK[b];
      end
      // idle only leaves through the clear strobe
      assign hw_clr[b] = hw_event_clear[b] & HW_CLR_MASK[b];
    end
  endgenerate

  // ****************************************************
  // sticky flags
  // ****************************************************
  // bits 15 and 11 get no cell at all and read as constant zero
  generate
    genvar f;
    for (f = 0; f < `PFC_DATA_W; f = f + 1) begin : g_flag
      if (IMPL_MASK[f]) begin : g_cell
        pfc_flag_cell u_cell (
          .clk_sys(clk_sys),
          .srst(srst),
          .ce(ce),
          .set_hw(hw_set[f]),
          .set_sw(sw_set[f]),
          .clr_hw(hw_clr[f]),
          .clr_sw(sw_clr[f]),
          .flag_q(event_status_flags[f])
        );
      end else begin : g_none
        assign event_status_flags[f] = 1'b0;
      end
    end
  endgenerate

  // ****************************************************
  // requests and side outputs
  // ****************************************************
  // requests follow the flag one cycle later; both software- and
  // hardware-set flags go through the same gate
  wire [`PFC_DATA_W-1:0] irq_gated;
  reg [`PFC_IRQ_W-1:0] irq_request_d;
  reg auto_idle_enable_d;
  reg idle_entry_d;

  assign irq_gated = event_status_flags & irq_en_q & IRQ_MASK;

  always @* begin
    irq_request_d = irq_gated[`PFC_IRQ_W-1:0];
    auto_idle_enable_d = irq_en_d[`PFC_BIT_IDLE];
    // idle is a function, not a request: it drives the output
    // passivation outside, never irq_request_q
    idle_entry_d = event_status_flags[`PFC_BIT_IDLE];
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      irq_request_q <= `PFC_RST_IRQ;
      auto_idle_enable_q <= 1'b0;
      idle_entry_q <= 1'b0;
    end else if (ce) begin
      irq_request_q <= irq_request_d;
      auto_idle_enable_q <= auto_idle_enable_d;
      idle_entry_q <= idle_entry_d;
    end
  end

  // ****************************************************
  // read path
  // ****************************************************
  // a read in the same cycle as an enable write returns the old value
  reg [`PFC_DATA_W-1:0] rdata_d;

  always @* begin
    rdata_d = `PFC_ZERO;
    case (rd_sel)
      `PFC_SEL_SET: rdata_d = `PFC_ZERO;
      `PFC_SEL_CLR: rdata_d = `PFC_ZERO;
      `PFC_SEL_EN: rdata_d = irq_en_q & IMPL_MASK;
      default: rdata_d = `PFC_ZERO;
    endcase
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata_q <= `PFC_RST_RDATA;
      reg_rvalid_q <= 1'b0;
    end else if (ce) begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd) begin
        reg_rdata_q <= rdata_d;
      end
    end
  end

endmodule // pfc_flag_ctrl
